/* shared/wake_frame_error_monitor_consts.svh */
// constants for the selective-wake frame error monitor
`ifndef WAKE_FRAME_ERROR_MONITOR_CONSTS_SVH
`define WAKE_FRAME_ERROR_MONITOR_CONSTS_SVH

`define ADDR_CFG_FIRST     8'h30
`define ADDR_CFG_LAST      8'h44
`define ADDR_ERR_COUNT     8'h45
`define ADDR_ERR_LIMIT     8'h46
`define ADDR_SETUP_STATUS  8'h47
`define ADDR_RSVD_FIRST    8'h48
`define ADDR_RSVD_LAST     8'h4F
`define ADDR_INT_FIRST     8'h51

`define BIT_SETUP_DONE     7
`define BIT_FD_DECODE_OK   6
`define BIT_CLASSIC_OK     5
`define BIT_OVERFLOW       3

`define RST_ERR_COUNT      8'h00
`define RST_ERR_LIMIT      8'h1F
`define RST_BYTE_ZERO      8'h00

`endif

/* shared/wake_frame_error_monitor_pkg.sv */
// types for the selective-wake frame error monitor
`default_nettype none
package wake_frame_error_monitor_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef enum logic [2:0] {
      EV_NONE  = 3'b001,
      EV_ERROR = 3'b010,
      EV_GOOD  = 3'b100
   } count_event_t;
endpackage
`default_nettype wire

/* logic/wake_frame_error_monitor.sv */
// frame error counter, overflow flag and configuration status of the wake decoder
`timescale 1ns/1ps
`default_nettype none
`include "wake_frame_error_monitor_consts.svh"

module wake_frame_error_monitor
   import wake_frame_error_monitor_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire logic      ce,
   // register access from the serial port decoder
   input  wire logic      regWrite,
   input  wire logic      regRead,
   input  wire reg_byte_t regAddr,
   input  wire reg_byte_t regWdata,
   output reg_byte_t      regRdata,
   // frame decoder results
   input  wire logic      frameDone,
   input  wire logic      frameError,
   input  wire logic      frameIsFd,
   input  wire logic      classicDecodeGood,
   input  wire logic      fdDecodeGood,
   // configuration held elsewhere
   input  wire logic      fdFrameIgnore,
   input  wire logic      frameDetectEn,
   input  wire logic      busIdleDetectEn,
   // status
   output reg_byte_t      frameErrorCount,
   output reg_byte_t      frameErrorLimit,
   output logic           frameErrorOverflowFlag,
   output logic           wakeSetupDone,
   output logic           classicDecodeOk,
   output logic           fdDecodeOk
);

   // ****************************************************************
   // access decode
   // ****************************************************************
   logic wrCfgRange;
   logic wrLimit;
   logic wrStatus;
   logic wrInt;
   logic rdStatus;
   logic rdReserved;

   assign wrCfgRange = regWrite && (regAddr >= `ADDR_CFG_FIRST) && (regAddr <= `ADDR_CFG_LAST);
   assign wrLimit    = regWrite && (regAddr == `ADDR_ERR_LIMIT);
   assign wrStatus   = regWrite && (regAddr == `ADDR_SETUP_STATUS);
   assign wrInt      = regWrite && (regAddr == `ADDR_INT_FIRST);
   assign rdStatus   = regRead && (regAddr == `ADDR_SETUP_STATUS);
   assign rdReserved = regRead && (regAddr >= `ADDR_RSVD_FIRST) && (regAddr <= `ADDR_RSVD_LAST);

   // ****************************************************************
   // frame classification
   // ****************************************************************
   logic         prevFrameDetectEn;
   logic         prevBusIdleDetectEn;
   logic         countClear;
   logic         fdIgnored;
   count_event_t countEvent;

   assign countClear = (frameDetectEn && !prevFrameDetectEn)
                     || (busIdleDetectEn && !prevBusIdleDetectEn);

   assign fdIgnored = frameIsFd && fdFrameIgnore;

   always_comb begin
      countEvent = EV_NONE;
      if (frameDone && !fdIgnored) begin
         if (frameError || frameIsFd) begin
            countEvent = EV_ERROR;
         end else begin
            countEvent = EV_GOOD;
         end
      end
   end

   // ****************************************************************
   // counter and overflow
   // ****************************************************************
   reg_byte_t next_frameErrorCount;
   logic      next_frameErrorOverflowFlag;
   logic      overflowEvent;

   assign overflowEvent = !countClear && (countEvent == EV_ERROR)
                        && (frameErrorCount == frameErrorLimit);

   always_comb begin
      next_frameErrorCount = frameErrorCount;
      if (countClear) begin
         next_frameErrorCount = `RST_ERR_COUNT;
      end else begin
         unique case (countEvent)
            EV_NONE: begin
               next_frameErrorCount = frameErrorCount;
            end
            EV_ERROR: begin
               if (overflowEvent) begin
                  next_frameErrorCount = `RST_ERR_COUNT;
               end else begin
                  next_frameErrorCount = frameErrorCount + 8'h01;
               end
            end
            EV_GOOD: begin
               if (frameErrorCount != `RST_ERR_COUNT) begin
                  next_frameErrorCount = frameErrorCount - 8'h01;
               end
            end
            default: begin
               next_frameErrorCount = frameErrorCount;
            end
         endcase
      end
   end

   always_comb begin
      next_frameErrorOverflowFlag = frameErrorOverflowFlag;
      if (wrInt && regWdata[`BIT_OVERFLOW]) begin
         next_frameErrorOverflowFlag = 1'b0;
      end
      if (overflowEvent) begin
         next_frameErrorOverflowFlag = 1'b1;
      end
   end

   // ****************************************************************
   // configuration and decode status
   // ****************************************************************
   reg_byte_t next_frameErrorLimit;
   logic      next_wakeSetupDone;
   logic      next_classicDecodeOk;
   logic      next_fdDecodeOk;
   reg_byte_t next_regRdata;

   always_comb begin
      next_frameErrorLimit = frameErrorLimit;
      if (wrLimit) begin
         next_frameErrorLimit = regWdata;
      end
   end

   always_comb begin
      next_wakeSetupDone = wakeSetupDone;
      if (wrStatus) begin
         next_wakeSetupDone = regWdata[`BIT_SETUP_DONE];
      end
      if (wrCfgRange || wrLimit) begin
         next_wakeSetupDone = 1'b0;
      end
   end

   always_comb begin
      next_classicDecodeOk = classicDecodeOk;
      next_fdDecodeOk      = fdDecodeOk;
      if (rdStatus) begin
         next_classicDecodeOk = 1'b0;
         next_fdDecodeOk      = 1'b0;
      end
      if (frameDone) begin
         next_classicDecodeOk = !frameIsFd && classicDecodeGood;
         next_fdDecodeOk      = frameIsFd && fdDecodeGood;
      end
      if (!frameDetectEn) begin
         next_classicDecodeOk = 1'b0;
         next_fdDecodeOk      = 1'b0;
      end
   end

   always_comb begin
      next_regRdata = regRdata;
      if (regRead) begin
         next_regRdata = `RST_BYTE_ZERO;
         unique case (regAddr)
            `ADDR_ERR_COUNT: begin
               next_regRdata = frameErrorCount;
            end
            `ADDR_ERR_LIMIT: begin
               next_regRdata = frameErrorLimit;
            end
            `ADDR_SETUP_STATUS: begin
               next_regRdata[`BIT_SETUP_DONE]   = wakeSetupDone;
               next_regRdata[`BIT_FD_DECODE_OK] = fdDecodeOk;
               next_regRdata[`BIT_CLASSIC_OK]   = classicDecodeOk;
            end
            `ADDR_INT_FIRST: begin
               next_regRdata[`BIT_OVERFLOW] = frameErrorOverflowFlag;
            end
            default: begin
               next_regRdata = `RST_BYTE_ZERO;
            end
         endcase
      end
   end

   // ****************************************************************
   // state registers
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         frameErrorCount        <= `RST_ERR_COUNT;
         frameErrorLimit        <= `RST_ERR_LIMIT;
         frameErrorOverflowFlag <= 1'b0;
         wakeSetupDone          <= 1'b0;
         classicDecodeOk        <= 1'b0;
         fdDecodeOk             <= 1'b0;
         regRdata               <= `RST_BYTE_ZERO;
         prevFrameDetectEn      <= 1'b0;
         prevBusIdleDetectEn    <= 1'b0;
      end else if (ce) begin
         frameErrorCount        <= next_frameErrorCount;
         frameErrorLimit        <= next_frameErrorLimit;
         frameErrorOverflowFlag <= next_frameErrorOverflowFlag;
         wakeSetupDone          <= next_wakeSetupDone;
         classicDecodeOk        <= next_classicDecodeOk;
         fdDecodeOk             <= next_fdDecodeOk;
         regRdata               <= next_regRdata;
         prevFrameDetectEn      <= frameDetectEn;
         prevBusIdleDetectEn    <= busIdleDetectEn;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence seq_error_taken;
      ce && !countClear && (countEvent == EV_ERROR);
   endsequence

   sequence seq_good_taken;
      ce && !countClear && (countEvent == EV_GOOD);
   endsequence

   sequence seq_status_read_quiet;
      ce && rdStatus && !frameDone ##1 ce && !frameDone;
   endsequence

   chk_count_up: assert property (
      seq_error_taken and (frameErrorCount != frameErrorLimit)
      |=> frameErrorCount == $past(frameErrorCount) + 8'h01)
      else $error("count did not rise on an error frame");

   chk_count_down: assert property (
      seq_good_taken and (frameErrorCount != 8'h00)
      |=> frameErrorCount == $past(frameErrorCount) - 8'h01)
      else $error("count did not fall on a good frame");

   chk_count_floor: assert property (
      seq_good_taken and (frameErrorCount == 8'h00) |=> frameErrorCount == 8'h00)
      else $error("count went below zero");

   chk_fd_ignored: assert property (
      ce && !countClear && frameDone && frameIsFd && fdFrameIgnore
      |=> $stable(frameErrorCount) && !$rose(frameErrorOverflowFlag))
      else $error("ignored fd frame changed the count");

   chk_fd_counted: assert property (
      ce && !countClear && frameDone && frameIsFd && !fdFrameIgnore
      && (frameErrorCount != frameErrorLimit)
      |=> frameErrorCount == $past(frameErrorCount) + 8'h01)
      else $error("fd frame not counted as error");

   chk_overflow_set: assert property (
      seq_error_taken and (frameErrorCount == frameErrorLimit)
      |=> frameErrorOverflowFlag && frameErrorCount == 8'h00)
      else $error("overflow not raised at the limit");

   chk_overflow_w1c: assert property (
      ce && wrInt && regWdata[`BIT_OVERFLOW] && !overflowEvent |=> !frameErrorOverflowFlag)
      else $error("overflow flag not cleared by write one");

   chk_count_clear: assert property (
      ce && countClear |=> frameErrorCount == 8'h00)
      else $error("count not cleared on detection enable");

   chk_setup_clear: assert property (
      ce && (wrCfgRange || wrLimit) |=> !wakeSetupDone)
      else $error("setup done survived a configuration write");

   chk_decode_off: assert property (
      ce && !frameDetectEn |=> !classicDecodeOk && !fdDecodeOk)
      else $error("decode flag set with detection off");

   chk_read_clear: assert property (
      seq_status_read_quiet |-> !classicDecodeOk && !fdDecodeOk)
      else $error("decode flags not cleared by status read");

   chk_reserved_zero: assert property (
      ce && rdReserved |=> regRdata == 8'h00)
      else $error("reserved register read nonzero");

endmodule
`default_nettype wire

/* sim/can_frame_source.sv */
// behavioural CAN node model driving the frame decoder result port
`timescale 1ns/1ps
`default_nettype none
module can_frame_source (
   input  wire logic clk,
   input  wire logic sendReq,
   input  wire logic sendErr,
   input  wire logic sendFd,
   input  wire logic sendGood,
   output logic      frameDone,
   output logic      frameError,
   output logic      frameIsFd,
   output logic      classicDecodeGood,
   output logic      fdDecodeGood
);
   initial begin
      {frameDone, frameError, frameIsFd, classicDecodeGood, fdDecodeGood} = 5'h00;
   end
   // qualifiers toggle outside frames, never hold a stale value
   always @(posedge clk) begin
      frameDone <= sendReq;
      if (sendReq) begin
         frameError <= sendErr;
         frameIsFd <= sendFd;
         classicDecodeGood <= sendGood & ~sendFd;
         fdDecodeGood <= sendGood & sendFd;
      end else begin
         {frameError, frameIsFd, classicDecodeGood, fdDecodeGood} <=
            ~{frameError, frameIsFd, classicDecodeGood, fdDecodeGood};
      end
   end
endmodule
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the frame error monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import wake_frame_error_monitor_pkg::*;
   logic      clk, rst_n, regWrite, regRead, fdFrameIgnore, frameDetectEn, busIdleDetectEn;
   logic      sendReq, sendErr, sendFd, sendGood, ce;
   logic      frameDone, frameError, frameIsFd, classicDecodeGood, fdDecodeGood;
   logic      frameErrorOverflowFlag, wakeSetupDone, classicDecodeOk, fdDecodeOk;
   reg_byte_t regAddr, regWdata, regRdata, frameErrorCount, frameErrorLimit;
   int        error_cnt, checks_done;
   int        i;

   wake_frame_error_monitor wake_frame_error_monitor_i (.clk(clk), .rst_n(rst_n), .ce(ce),
      .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
      .regRdata(regRdata), .frameDone(frameDone), .frameError(frameError),
      .frameIsFd(frameIsFd), .classicDecodeGood(classicDecodeGood),
      .fdDecodeGood(fdDecodeGood), .fdFrameIgnore(fdFrameIgnore),
      .frameDetectEn(frameDetectEn), .busIdleDetectEn(busIdleDetectEn),
      .frameErrorCount(frameErrorCount), .frameErrorLimit(frameErrorLimit),
      .frameErrorOverflowFlag(frameErrorOverflowFlag), .wakeSetupDone(wakeSetupDone),
      .classicDecodeOk(classicDecodeOk), .fdDecodeOk(fdDecodeOk));

   can_frame_source can_frame_source_i (.clk(clk), .sendReq(sendReq), .sendErr(sendErr),
      .sendFd(sendFd), .sendGood(sendGood), .frameDone(frameDone), .frameError(frameError),
      .frameIsFd(frameIsFd), .classicDecodeGood(classicDecodeGood),
      .fdDecodeGood(fdDecodeGood));

   // ********************
   // access tasks
   // ********************
   task automatic chk(input reg_byte_t seen, input reg_byte_t exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input reg_byte_t a, input reg_byte_t d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input reg_byte_t a, input reg_byte_t exp);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      chk(regRdata, exp);
   endtask

   // n frames back to back, outputs settled on return
   task automatic frame(input int n, input logic e, input logic fd, input logic g);
      @(posedge clk);
      sendReq <= 1'b1;
      sendErr <= e;
      sendFd <= fd;
      sendGood <= g;
      repeat (n) @(posedge clk);
      sendReq <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ********************
   // tests
   // ********************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      #(50 * 8000);
      error_cnt++;
      results();
   end

   initial begin
      {rst_n, regWrite, regRead, fdFrameIgnore, frameDetectEn, busIdleDetectEn} = 6'h00;
      {sendReq, sendErr, sendFd, sendGood} = 4'h0;
      regAddr = 8'h00;
      regWdata = 8'h00;
      ce = 1'b1;
      error_cnt = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h45, 8'h00);
      rd(8'h46, 8'h1F);
      rd(8'h47, 8'h00);
      rd(8'h51, 8'h00);
      for (i = 8'h48; i <= 8'h4F; i++) begin
         wr(i[7:0], 8'hFF);
         rd(i[7:0], 8'h00);
      end
      rd(8'h33, 8'h00);
      $display("test reset done");
      @(posedge clk);
      frameDetectEn <= 1'b1;
      frame(31, 1'b1, 1'b0, 1'b0);
      chk(frameErrorCount, 8'h1F);
      chk({7'h00, frameErrorOverflowFlag}, 8'h00);
      frame(1, 1'b1, 1'b0, 1'b0);
      chk({7'h00, frameErrorOverflowFlag}, 8'h01);
      wr(8'h51, 8'h00);
      rd(8'h51, 8'h08);
      wr(8'h51, 8'h08);
      rd(8'h51, 8'h00);
      $display("test default limit done");
      // software sets the done bit as the last step
      wr(8'h47, 8'hFF);
      rd(8'h47, 8'h80);
      chk({7'h00, wakeSetupDone}, 8'h01);
      wr(8'h30, 8'h00);
      rd(8'h47, 8'h00);
      wr(8'h47, 8'h80);
      wr(8'h44, 8'h00);
      rd(8'h47, 8'h00);
      wr(8'h47, 8'h80);
      wr(8'h45, 8'h12);
      rd(8'h47, 8'h80);
      rd(8'h45, 8'h00);
      wr(8'h46, 8'h03);
      rd(8'h47, 8'h00);
      rd(8'h46, 8'h03);
      chk(frameErrorLimit, 8'h03);
      $display("test setup status done");
      frame(3, 1'b1, 1'b0, 1'b0);
      rd(8'h45, 8'h03);
      frame(1, 1'b0, 1'b0, 1'b1);
      rd(8'h45, 8'h02);
      frame(3, 1'b0, 1'b0, 1'b1);
      rd(8'h45, 8'h00);
      frame(4, 1'b1, 1'b0, 1'b0);
      rd(8'h51, 8'h08);
      wr(8'h51, 8'h08);
      frame(2, 1'b1, 1'b0, 1'b0);
      rd(8'h51, 8'h00);
      frame(1, 1'b0, 1'b1, 1'b1);
      rd(8'h45, 8'h03);
      @(posedge clk);
      fdFrameIgnore <= 1'b1;
      frame(2, 1'b1, 1'b1, 1'b0);
      frame(1, 1'b0, 1'b1, 1'b1);
      rd(8'h45, 8'h03);
      rd(8'h51, 8'h00);
      $display("test counter done");
      @(posedge clk);
      frameDetectEn <= 1'b0;
      @(posedge clk);
      frameDetectEn <= 1'b1;
      rd(8'h45, 8'h00);
      frame(2, 1'b1, 1'b0, 1'b0);
      @(posedge clk);
      busIdleDetectEn <= 1'b1;
      rd(8'h45, 8'h00);
      $display("test count clear done");
      frame(1, 1'b0, 1'b0, 1'b1);
      chk({6'h00, fdDecodeOk, classicDecodeOk}, 8'h01);
      rd(8'h47, 8'h20);
      rd(8'h47, 8'h00);
      frame(1, 1'b0, 1'b1, 1'b1);
      chk({6'h00, fdDecodeOk, classicDecodeOk}, 8'h02);
      rd(8'h47, 8'h40);
      frame(1, 1'b0, 1'b0, 1'b1);
      frame(1, 1'b0, 1'b0, 1'b0);
      rd(8'h47, 8'h00);
      $display("test decode flags done");
      @(posedge clk);
      ce <= 1'b0;
      frame(2, 1'b1, 1'b0, 1'b0);
      chk(frameErrorCount, 8'h00);
      @(posedge clk);
      ce <= 1'b1;
      frame(1, 1'b1, 1'b0, 1'b0);
      chk(frameErrorCount, 8'h01);
      $display("test clock enable done");
      results();
   end
endmodule
`default_nettype wire
